/* File: design/srap_pkg.sv */
// Constants and types shared by the serial register access port
package srap_pkg;

   // ----------------------------------------------------------------
   // Data set layout
   // ----------------------------------------------------------------
   localparam int SRAP_SET_BITS = 24;
   localparam int SRAP_HDR_BITS = 8;
   localparam int SRAP_ADDR_W = 6;
   localparam int SRAP_DATA_W = 16;
   localparam int SRAP_CNT_W = 5;
   localparam int SRAP_ADDR_LSB = 0;
   localparam int SRAP_SEL_POS = 6;
   localparam int SRAP_SPARE_POS = 7;
   localparam int SRAP_DATA_LSB = 8;
   // Bit position of the header inside the shifter once only the header is in
   localparam int SRAP_HDR_OFS = SRAP_SET_BITS - SRAP_HDR_BITS;
   localparam logic [SRAP_CNT_W-1:0] SRAP_HDR_LAST = 5'h07;
   localparam logic [SRAP_CNT_W-1:0] SRAP_SET_LAST = 5'h17;
   localparam logic [SRAP_CNT_W-1:0] SRAP_CNT_ONE = 5'h01;
   localparam logic SRAP_SEL_WRITE = 1'b0;
   localparam logic SRAP_SEL_READ = 1'b1;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [SRAP_DATA_W-1:0] SRAP_REG_RESET = 16'h0000;
   localparam int SRAP_NUM_REGS = 13;
   localparam int SRAP_CONV_W = 10;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_IRIS_DUTY_OVERRIDE = 6'h0A;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_IRIS_MODE_AND_POLARITY = 6'h0B;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_IRIS_CONVERTER_RESULT = 6'h0C;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_IRIS_TARGET_UPDATE_TIMING = 6'h0E;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_STEPPER_WAIT_AND_PWM = 6'h20;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_PULSE_PIN_SELECT_TEST = 6'h21;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_ALPHA_WAIT_PHASE = 6'h22;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_DRIVER_AB_PEAK_WIDTH = 6'h23;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_ALPHA_STEP_CONTROL = 6'h24;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_ALPHA_STEP_CYCLE = 6'h25;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_BETA_WAIT_PHASE = 6'h27;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_DRIVER_CD_PEAK_WIDTH = 6'h28;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_BETA_STEP_CONTROL = 6'h29;
   localparam logic [SRAP_ADDR_W-1:0] SRAP_ADDR_MOTOR_BETA_STEP_CYCLE = 6'h2A;

   // Writable registers, in bank order
   localparam logic [SRAP_ADDR_W-1:0] SRAP_RW_ADDR [SRAP_NUM_REGS] = '{
      SRAP_ADDR_IRIS_DUTY_OVERRIDE,
      SRAP_ADDR_IRIS_MODE_AND_POLARITY,
      SRAP_ADDR_IRIS_TARGET_UPDATE_TIMING,
      SRAP_ADDR_STEPPER_WAIT_AND_PWM,
      SRAP_ADDR_PULSE_PIN_SELECT_TEST,
      SRAP_ADDR_MOTOR_ALPHA_WAIT_PHASE,
      SRAP_ADDR_DRIVER_AB_PEAK_WIDTH,
      SRAP_ADDR_MOTOR_ALPHA_STEP_CONTROL,
      SRAP_ADDR_MOTOR_ALPHA_STEP_CYCLE,
      SRAP_ADDR_MOTOR_BETA_WAIT_PHASE,
      SRAP_ADDR_DRIVER_CD_PEAK_WIDTH,
      SRAP_ADDR_MOTOR_BETA_STEP_CONTROL,
      SRAP_ADDR_MOTOR_BETA_STEP_CYCLE
   };

   // ----------------------------------------------------------------
   // Port sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SRAP_ST_IDLE = 4'h1,
      SRAP_ST_HDR = 4'h2,
      SRAP_ST_WR = 4'h4,
      SRAP_ST_RD = 4'h8
   } srap_state_t;

endpackage

/* File: design/srap_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module srap_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] level_next;

   // Accept a new level only where stages two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         level_reg <= RESET_VAL;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level_o = level_reg;
endmodule

/* File: design/srap_regfile.sv */
// Control register bank with write port and read multiplexer
`timescale 1ns/1ps
module srap_regfile
   import srap_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic wr_stb_i,
   input wire logic [srap_pkg::SRAP_ADDR_W-1:0] wr_addr_i,
   input wire logic [srap_pkg::SRAP_DATA_W-1:0] wr_data_i,
   input wire logic [srap_pkg::SRAP_ADDR_W-1:0] rd_addr_i,
   input wire logic [srap_pkg::SRAP_CONV_W-1:0] iris_converter_value_i,
   output logic [srap_pkg::SRAP_DATA_W-1:0] rd_data_o,
   output logic [srap_pkg::SRAP_NUM_REGS*srap_pkg::SRAP_DATA_W-1:0] bank_o
);
   import srap_pkg::*;

   logic [SRAP_DATA_W-1:0] bank_reg [SRAP_NUM_REGS];
   logic [SRAP_DATA_W-1:0] bank_next [SRAP_NUM_REGS];

   // Only listed addresses store; converter result and holes ignore writes
   always_comb begin
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         bank_next[i] = bank_reg[i];
         if (clear_i) begin
            bank_next[i] = SRAP_REG_RESET;
         end else if (wr_stb_i && (wr_addr_i == SRAP_RW_ADDR[i])) begin
            bank_next[i] = wr_data_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         if (rst_i) begin
            bank_reg[i] <= SRAP_REG_RESET;
         end else begin
            bank_reg[i] <= bank_next[i];
         end
      end
   end

   // Read mux: unmapped addresses and unused upper bits read zero
   always_comb begin
      rd_data_o = '0;
      if (rd_addr_i == SRAP_ADDR_IRIS_CONVERTER_RESULT) begin
         rd_data_o = {{(SRAP_DATA_W-SRAP_CONV_W){1'b0}}, iris_converter_value_i};
      end
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         if (rd_addr_i == SRAP_RW_ADDR[i]) begin
            rd_data_o = bank_reg[i];
         end
      end
   end

   for (genvar g = 0; g < SRAP_NUM_REGS; g++) begin : g_flat
      assign bank_o[g*SRAP_DATA_W +: SRAP_DATA_W] = bank_reg[g];
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   read_only_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_stb_i && !clear_i && wr_addr_i == SRAP_ADDR_IRIS_CONVERTER_RESULT) |=> $stable(bank_o))
      else $error("write to converter result changed the bank");
   unmapped_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (rd_addr_i < SRAP_ADDR_IRIS_DUTY_OVERRIDE || rd_addr_i == 6'h0D || rd_addr_i == 6'h26 ||
       rd_addr_i > SRAP_ADDR_MOTOR_BETA_STEP_CYCLE) |-> rd_data_o == 16'h0000)
      else $error("unmapped address read nonzero");
endmodule

/* File: design/srap_top.sv */
// Serial register access port: framing, shifting, read-out and register bank
`timescale 1ns/1ps
module srap_top
   import srap_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic chip_select_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic reset_n_i,
   input wire logic [srap_pkg::SRAP_CONV_W-1:0] iris_converter_value_i,
   output logic serial_out_o,
   output logic serial_out_oe_n_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] iris_duty_override_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] iris_mode_and_polarity_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] iris_target_update_timing_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] stepper_wait_and_pwm_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] pulse_pin_select_test_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_alpha_wait_phase_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] driver_ab_peak_width_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_alpha_step_control_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_alpha_step_cycle_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_beta_wait_phase_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] driver_cd_peak_width_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_beta_step_control_o,
   output logic [srap_pkg::SRAP_DATA_W-1:0] motor_beta_step_cycle_o
);
   import srap_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [3:0] pins_f;
   logic cs_f;
   logic sck_f;
   logic sin_f;
   logic reset_n_f;
   logic port_clr;
   logic sck_prev_reg;
   logic sck_rise;

   srap_pin_sync #(
      .WIDTH(4),
      .RESET_VAL(4'h8)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .pin_i({reset_n_i, serial_in_i, serial_clk_i, chip_select_i}),
      .level_o(pins_f)
   );

   assign cs_f = pins_f[0];
   assign sck_f = pins_f[1];
   assign sin_f = pins_f[2];
   assign reset_n_f = pins_f[3];
   assign port_clr = !reset_n_f;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sck_prev_reg <= 1'b0;
      end else begin
         sck_prev_reg <= sck_f;
      end
   end

   assign sck_rise = sck_f && !sck_prev_reg;

   // ----------------------------------------------------------------
   // Frame sequencer and shifter
   // ----------------------------------------------------------------
   srap_state_t state_reg;
   srap_state_t state_next;
   logic [SRAP_CNT_W-1:0] cnt_reg;
   logic [SRAP_CNT_W-1:0] cnt_next;
   logic [SRAP_SET_BITS-1:0] shift_reg;
   logic [SRAP_SET_BITS-1:0] shift_next;
   logic [SRAP_SET_BITS-1:0] shifted;
   logic [SRAP_DATA_W-1:0] rd_shift_reg;
   logic [SRAP_DATA_W-1:0] rd_shift_next;
   logic serial_out_reg;
   logic serial_out_next;
   logic oe_n_reg;
   logic oe_n_next;
   logic wr_stb_reg;
   logic wr_stb_next;
   logic [SRAP_ADDR_W-1:0] wr_addr_reg;
   logic [SRAP_ADDR_W-1:0] wr_addr_next;
   logic [SRAP_DATA_W-1:0] wr_data_reg;
   logic [SRAP_DATA_W-1:0] wr_data_next;
   logic [SRAP_ADDR_W-1:0] rd_addr;
   logic [SRAP_DATA_W-1:0] rd_data;
   logic hdr_sel;

   // LSB first: each new bit enters at the top and walks down
   assign shifted = {sin_f, shift_reg[SRAP_SET_BITS-1:1]};
   assign rd_addr = shifted[SRAP_HDR_OFS+SRAP_ADDR_LSB +: SRAP_ADDR_W];
   assign hdr_sel = shifted[SRAP_HDR_OFS+SRAP_SEL_POS];

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      rd_shift_next = rd_shift_reg;
      serial_out_next = serial_out_reg;
      oe_n_next = !cs_f;
      wr_stb_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      if (port_clr || !cs_f) begin
         // Closing the frame drops any partial set
         state_next = SRAP_ST_IDLE;
         cnt_next = '0;
         shift_next = '0;
         rd_shift_next = '0;
         serial_out_next = 1'b0;
         oe_n_next = 1'b1;
      end else if (sck_rise) begin
         shift_next = shifted;
         case (state_reg)
            SRAP_ST_IDLE, SRAP_ST_HDR: begin
               serial_out_next = 1'b0;
               cnt_next = cnt_reg + SRAP_CNT_ONE;
               state_next = SRAP_ST_HDR;
               if (cnt_reg == SRAP_HDR_LAST) begin
                  if (hdr_sel == SRAP_SEL_READ) begin
                     state_next = SRAP_ST_RD;
                     serial_out_next = rd_data[0];
                     rd_shift_next = {1'b0, rd_data[SRAP_DATA_W-1:1]};
                  end else begin
                     state_next = SRAP_ST_WR;
                  end
               end
            end
            SRAP_ST_WR: begin
               if (cnt_reg == SRAP_SET_LAST) begin
                  // Full set received: commit and start the next set
                  cnt_next = '0;
                  state_next = SRAP_ST_HDR;
                  wr_stb_next = 1'b1;
                  wr_addr_next = shifted[SRAP_ADDR_LSB +: SRAP_ADDR_W];
                  wr_data_next = shifted[SRAP_DATA_LSB +: SRAP_DATA_W];
               end else begin
                  cnt_next = cnt_reg + SRAP_CNT_ONE;
               end
            end
            SRAP_ST_RD: begin
               // Input bits in these positions are never used
               if (cnt_reg == SRAP_SET_LAST) begin
                  cnt_next = '0;
                  state_next = SRAP_ST_HDR;
                  serial_out_next = 1'b0;
               end else begin
                  cnt_next = cnt_reg + SRAP_CNT_ONE;
                  serial_out_next = rd_shift_reg[0];
                  rd_shift_next = {1'b0, rd_shift_reg[SRAP_DATA_W-1:1]};
               end
            end
            default: begin
               state_next = SRAP_ST_IDLE;
               cnt_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_reg <= SRAP_ST_IDLE;
         cnt_reg <= '0;
         shift_reg <= '0;
         rd_shift_reg <= '0;
         serial_out_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         wr_stb_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         rd_shift_reg <= rd_shift_next;
         serial_out_reg <= serial_out_next;
         oe_n_reg <= oe_n_next;
         wr_stb_reg <= wr_stb_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
      end
   end

   assign serial_out_o = serial_out_reg;
   assign serial_out_oe_n_o = oe_n_reg;

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   logic [SRAP_NUM_REGS*SRAP_DATA_W-1:0] bank;

   srap_regfile u_regs (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clear_i(port_clr),
      .wr_stb_i(wr_stb_reg),
      .wr_addr_i(wr_addr_reg),
      .wr_data_i(wr_data_reg),
      .rd_addr_i(rd_addr),
      .iris_converter_value_i(iris_converter_value_i),
      .rd_data_o(rd_data),
      .bank_o(bank)
   );

   assign iris_duty_override_o = bank[0*SRAP_DATA_W +: SRAP_DATA_W];
   assign iris_mode_and_polarity_o = bank[1*SRAP_DATA_W +: SRAP_DATA_W];
   assign iris_target_update_timing_o = bank[2*SRAP_DATA_W +: SRAP_DATA_W];
   assign stepper_wait_and_pwm_o = bank[3*SRAP_DATA_W +: SRAP_DATA_W];
   assign pulse_pin_select_test_o = bank[4*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_alpha_wait_phase_o = bank[5*SRAP_DATA_W +: SRAP_DATA_W];
   assign driver_ab_peak_width_o = bank[6*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_alpha_step_control_o = bank[7*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_alpha_step_cycle_o = bank[8*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_beta_wait_phase_o = bank[9*SRAP_DATA_W +: SRAP_DATA_W];
   assign driver_cd_peak_width_o = bank[10*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_beta_step_control_o = bank[11*SRAP_DATA_W +: SRAP_DATA_W];
   assign motor_beta_step_cycle_o = bank[12*SRAP_DATA_W +: SRAP_DATA_W];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   float_idle_a: assert property (!cs_f |=> serial_out_oe_n_o && !serial_out_o)
      else $error("serial output driven with chip select low");
   write_zero_a: assert property (state_reg == SRAP_ST_WR |-> !serial_out_o)
      else $error("serial output nonzero during write");
   cs_low_clear_a: assert property (!cs_f |=> cnt_reg == 5'h00 && state_reg == SRAP_ST_IDLE)
      else $error("port logic not cleared with chip select low");
   bit_count_a: assert property ((cs_f && !port_clr && sck_rise && cnt_reg != SRAP_SET_LAST)
      |=> cnt_reg == $past(cnt_reg) + 5'h01)
      else $error("bit counter did not advance on serial clock");
   commit_set_a: assert property ((cs_f && !port_clr && sck_rise && state_reg == SRAP_ST_WR &&
      cnt_reg == SRAP_SET_LAST) |=> wr_stb_reg ##1 !wr_stb_reg)
      else $error("full write set not committed for one cycle");
   short_drop_a: assert property (wr_stb_reg |-> $past(cnt_reg) == SRAP_SET_LAST &&
      $past(state_reg) == SRAP_ST_WR)
      else $error("write committed without a full set");
   read_first_a: assert property ((cs_f && !port_clr && sck_rise && cnt_reg == SRAP_HDR_LAST &&
      state_reg != SRAP_ST_WR && hdr_sel) |=> serial_out_o == $past(rd_data[0]) && state_reg == SRAP_ST_RD)
      else $error("read data bit zero not presented");
   read_hold_a: assert property ((state_reg == SRAP_ST_RD && !sck_rise && cs_f && !port_clr)
      |=> $stable(serial_out_o))
      else $error("read output changed without serial clock edge");
   reset_clear_a: assert property (port_clr |=> !wr_stb_reg && cnt_reg == 5'h00 ##1 bank == '0)
      else $error("reset pin did not clear the port");
   no_read_write_a: assert property (state_reg == SRAP_ST_RD |-> !wr_stb_reg)
      else $error("register write during a read set");
   hdr_zero_a: assert property (state_reg == SRAP_ST_HDR |-> !serial_out_o)
      else $error("serial output nonzero during a header");
   cs_drive_a: assert property ((cs_f && !port_clr) |=> !serial_out_oe_n_o)
      else $error("serial output not driven with chip select high");
   cnt_range_a: assert property (cnt_reg <= SRAP_SET_LAST)
      else $error("bit counter beyond one data set");
   read_tail_a: assert property ((cs_f && !port_clr && sck_rise && state_reg == SRAP_ST_RD &&
      cnt_reg == SRAP_SET_LAST) |=> !serial_out_o && state_reg == SRAP_ST_HDR)
      else $error("serial output not back to zero after read data");
   duty_load_a: assert property ((wr_stb_reg && !port_clr && wr_addr_reg == SRAP_ADDR_IRIS_DUTY_OVERRIDE)
      |=> iris_duty_override_o == $past(wr_data_reg))
      else $error("write did not reach the addressed register");
   beta_load_a: assert property ((wr_stb_reg && !port_clr && wr_addr_reg == SRAP_ADDR_MOTOR_BETA_STEP_CYCLE)
      |=> motor_beta_step_cycle_o == $past(wr_data_reg))
      else $error("write did not reach the addressed register");

   // Read sets shift exactly sixteen data bits before the next header
   logic [SRAP_CNT_W-1:0] rd_bits_reg;
   logic [SRAP_CNT_W-1:0] rd_bits_next;

   always_comb begin
      rd_bits_next = rd_bits_reg;
      if (state_reg != SRAP_ST_RD) begin
         rd_bits_next = '0;
      end else if (sck_rise && cs_f && !port_clr) begin
         rd_bits_next = rd_bits_reg + SRAP_CNT_ONE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_bits_reg <= '0;
      end else begin
         rd_bits_reg <= rd_bits_next;
      end
   end

   read_len_a: assert property (state_reg == SRAP_ST_RD |-> rd_bits_reg < 5'(SRAP_DATA_W))
      else $error("read set shifted too many data bits");
   read_done_a: assert property ((state_reg == SRAP_ST_HDR && $past(state_reg) == SRAP_ST_RD)
      |-> rd_bits_reg == 5'(SRAP_DATA_W))
      else $error("read set ended without sixteen data bits");

   write_seen_c: cover property (wr_stb_reg);
   burst_write_c: cover property (wr_stb_reg ##[2:400] (wr_stb_reg && cs_f));
   read_seen_c: cover property (state_reg == SRAP_ST_RD && cnt_reg == SRAP_SET_LAST);
   partial_drop_c: cover property (state_reg == SRAP_ST_WR && cnt_reg != 5'h00 && !cs_f);
endmodule

/* File: verif/srap_host_model.sv */
// Host-side serial master model that frames and clocks data sets into the port
`timescale 1ns/1ps
module srap_host_model (
   input wire logic clk_sys_i,
   input wire logic serial_out_i,
   input wire logic serial_out_oe_n_i,
   output logic chip_select_o,
   output logic serial_clk_o,
   output logic serial_in_o
);
   wire so_pin;

   // Pin floats whenever the port lets go of it
   assign so_pin = serial_out_oe_n_i ? 1'bz : serial_out_i;

   initial begin
      chip_select_o = 1'b0;
      serial_clk_o = 1'b0;
      serial_in_o = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // ----------------------------------------------------------------
   // Frame control
   // ----------------------------------------------------------------
   // Released data line shows the inverse of its last value
   task automatic cs_set(input logic v);
      chip_select_o = v;
      serial_in_o = ~serial_in_o;
      wait_clk(8);
   endtask

   // ----------------------------------------------------------------
   // One data set, LSB first; so[i] is the pin just before rise i
   // ----------------------------------------------------------------
   task automatic send_set(input logic [23:0] s, input int nbits, output logic [23:0] so);
      so = 24'h000000;
      for (int i = 0; i < nbits; i++) begin
         serial_clk_o = 1'b0;
         serial_in_o = s[i];
         wait_clk(5);
         so[i] = so_pin;
         serial_clk_o = 1'b1;
         wait_clk(5);
      end
      serial_clk_o = 1'b0;
      wait_clk(5);
   endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the serial register access port
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import srap_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i;
   logic reset_n_i;
   logic [SRAP_CONV_W-1:0] conv;
   logic cs;
   logic sclk;
   logic serial_in;
   logic so;
   logic so_oe_n;
   logic [SRAP_DATA_W-1:0] bank_w [SRAP_NUM_REGS];
   logic [SRAP_DATA_W-1:0] exp_q [SRAP_NUM_REGS];
   logic [23:0] so_v;
   int n_fail = 0;
   int n_checks = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   srap_host_model host_u (.clk_sys_i(clk_sys_i), .serial_out_i(so), .serial_out_oe_n_i(so_oe_n),
      .chip_select_o(cs), .serial_clk_o(sclk), .serial_in_o(serial_in));

   srap_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .chip_select_i(cs), .serial_clk_i(sclk),
      .serial_in_i(serial_in), .reset_n_i(reset_n_i), .iris_converter_value_i(conv), .serial_out_o(so),
      .serial_out_oe_n_o(so_oe_n), .iris_duty_override_o(bank_w[0]), .iris_mode_and_polarity_o(bank_w[1]),
      .iris_target_update_timing_o(bank_w[2]), .stepper_wait_and_pwm_o(bank_w[3]),
      .pulse_pin_select_test_o(bank_w[4]), .motor_alpha_wait_phase_o(bank_w[5]),
      .driver_ab_peak_width_o(bank_w[6]), .motor_alpha_step_control_o(bank_w[7]),
      .motor_alpha_step_cycle_o(bank_w[8]), .motor_beta_wait_phase_o(bank_w[9]),
      .driver_cd_peak_width_o(bank_w[10]), .motor_beta_step_control_o(bank_w[11]),
      .motor_beta_step_cycle_o(bank_w[12]));

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   function automatic logic [23:0] mk(logic [5:0] a, logic sel, logic sp, logic [15:0] d);
      return {d, sp, sel, a};
   endfunction

   task automatic note_wr(input logic [5:0] a, input logic [15:0] d);
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         if (SRAP_RW_ADDR[i] == a) begin
            exp_q[i] = d;
         end
      end
   endtask

   // Spare bit set on writes so that it is seen to be ignored
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host_u.cs_set(1'b1);
      host_u.send_set(mk(a, SRAP_SEL_WRITE, 1'b1, d), 24, so_v);
      host_u.cs_set(1'b0);
      note_wr(a, d);
      `CHK(so_v, 24'h000000)
   endtask

   // Data positions carry all ones, which the port must ignore
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      host_u.cs_set(1'b1);
      `CHK(so_oe_n, 1'b0)
      host_u.send_set(mk(a, SRAP_SEL_READ, 1'b0, 16'hFFFF), 24, so_v);
      host_u.cs_set(1'b0);
      `CHK(so_v, {e, 8'h00})
      `CHK(so_oe_n, 1'b1)
   endtask

   task automatic chk_bank();
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         `CHK(bank_w[i], exp_q[i])
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      reset_n_i = 1'b1;
      conv = 10'h2A5;
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         exp_q[i] = SRAP_REG_RESET;
      end
      repeat (2) @(negedge clk_sys_i);
      rst_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk_bank();
      `CHK(so_oe_n, 1'b1)
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         wr(SRAP_RW_ADDR[i], 16'hA51C ^ (16'(i) * 16'h1111));
      end
      chk_bank();
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         rd(SRAP_RW_ADDR[i], exp_q[i]);
      end
      rd(6'h0C, {6'h00, conv});
      wr(6'h0C, 16'hFFFF);
      wr(6'h26, 16'hFFFF);
      chk_bank();
      conv = 10'h15A;
      rd(6'h0C, {6'h00, conv});
      rd(6'h26, 16'h0000);
      host_u.cs_set(1'b1);
      host_u.send_set(mk(6'h0A, SRAP_SEL_WRITE, 1'b0, 16'h1234), 23, so_v);
      host_u.cs_set(1'b0);
      chk_bank();
      wr(6'h0A, 16'h5A5A);
      chk_bank();
      host_u.cs_set(1'b1);
      host_u.send_set(mk(6'h20, SRAP_SEL_WRITE, 1'b0, 16'h1111), 24, so_v);
      host_u.send_set(mk(6'h21, SRAP_SEL_WRITE, 1'b0, 16'h2222), 24, so_v);
      host_u.send_set(mk(6'h22, SRAP_SEL_WRITE, 1'b0, 16'h3333), 12, so_v);
      host_u.cs_set(1'b0);
      note_wr(6'h20, 16'h1111);
      note_wr(6'h21, 16'h2222);
      chk_bank();
      reset_n_i = 1'b0;
      repeat (10) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      for (int i = 0; i < SRAP_NUM_REGS; i++) begin
         exp_q[i] = SRAP_REG_RESET;
      end
      chk_bank();
      summarize();
   end

   // Roughly 34 frames of about 260 cycles each; far beyond that is a hang
   initial begin
      repeat (60000) @(negedge clk_sys_i);
      n_fail++;
      summarize();
   end
endmodule
